/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic sys_clk, nrst, ec_config_flag;
	ur_pkg::ur_port_wr_t [1:0] cc_port_wr, ec_port_wr;
	logic [1:0][7:0] cc_port_rd, ec_port_rd;
	logic [1:0] cc_port_event, ec_port_event, xcvr_connect, xcvr_hs_capable, attach, oc_req, oc_n;
	ur_pkg::ur_line_t [1:0] cc_tx, ec_tx, cc_rx, ec_rx, xcvr_tx, xcvr_rx;
	ur_pkg::ur_speed_t [1:0] cc_speed_req, xcvr_speed;
	logic port1_power_enable_n_in, port1_power_enable_n_out, port1_power_enable_n_oe_n;
	logic port2_power_enable_n_in, port2_power_enable_n_out, port2_power_enable_n_oe_n;
	int fails = 0, n_checks = 0, cyc = 0;
	// Open-drain pins read high through the board pull-up when released
	assign port1_power_enable_n_in = port1_power_enable_n_oe_n | port1_power_enable_n_out;
	assign port2_power_enable_n_in = port2_power_enable_n_oe_n | port2_power_enable_n_out;
	ur_port_router u_ur_port_router (.sys_clk, .nrst, .ec_config_flag, .cc_port_wr, .ec_port_wr,
		.cc_port_rd, .ec_port_rd, .cc_port_event, .ec_port_event, .cc_tx, .ec_tx, .cc_speed_req,
		.cc_rx, .ec_rx, .xcvr_tx, .xcvr_speed, .xcvr_rx, .xcvr_connect, .xcvr_hs_capable,
		.port1_power_enable_n_in, .port1_power_enable_n_out, .port1_power_enable_n_oe_n,
		.port2_power_enable_n_in, .port2_power_enable_n_out, .port2_power_enable_n_oe_n,
		.port1_overcurrent_n(oc_n[0]), .port2_overcurrent_n(oc_n[1]));
	ur_xcvr_model u_ur_xcvr_model (.sys_clk, .nrst, .xcvr_tx, .attach, .oc_req, .xcvr_rx,
		.xcvr_connect, .xcvr_hs_capable, .oc_n);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Hang guard, runs far beyond the whole sequence
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe; register visible once it returns
	task automatic wr(input logic ec, input int p, input logic [4:0] w);
		@(negedge sys_clk);
		if (ec) ec_port_wr[p] = w;
		else cc_port_wr[p] = w;
		@(negedge sys_clk);
		ec_port_wr[p] = '0;
		cc_port_wr[p] = '0;
	endtask
	task automatic t_reset();
		chk(ec_port_rd[0] & 8'h30, 8'h20);
		chk(ec_port_rd[1] & 8'h30, 8'h20);
		chk({7'h0, port2_power_enable_n_oe_n}, 8'h01);
		$display("reset done");
	endtask
	task automatic t_owner();
		wr(1'b0, 0, 5'b10100);
		chk({7'h0, port1_power_enable_n_oe_n}, 8'h00);
		chk({7'h0, port1_power_enable_n_in}, 8'h00);
		wr(1'b1, 0, 5'b10000);
		wr(1'b0, 0, 5'b10000);
		chk(ec_port_rd[0] & 8'h10, 8'h00);
		wr(1'b0, 0, 5'b10100);
		ec_config_flag = 1'b1;
		@(negedge sys_clk);
		chk({6'h0, ec_port_event[0], cc_port_event[0]}, 8'h02);
		wr(1'b0, 0, 5'b10000);
		chk(ec_port_rd[0] & 8'h30, 8'h10);
		chk(cc_port_rd[0] & 8'he0, 8'h00);
		$display("ownership done");
	endtask
	task automatic t_data();
		ec_tx[0] = '{valid: 1'b1, data: 8'h5a};
		cc_tx[0] = '{valid: 1'b1, data: 8'h33};
		repeat (4) @(negedge sys_clk);
		chk(xcvr_tx[0].data, 8'h5a);
		chk(8'(xcvr_speed[0]), 8'(ur_pkg::UR_SPEED_HS));
		chk(ec_rx[0].data, 8'ha5);
		chk({7'h0, cc_rx[0].valid}, 8'h00);
		chk(cc_rx[0].data, 8'h00);
		chk(ec_port_rd[0] & 8'hc0, 8'hc0);
		wr(1'b1, 0, 5'b10001);
		for (int s = 0; s < 3; s++) begin
			cc_speed_req[0] = ur_pkg::ur_speed_t'(s);
			repeat (2) @(negedge sys_clk);
			chk(xcvr_tx[0].data, 8'h33);
			chk(8'(xcvr_speed[0]), 8'(s == 1 ? ur_pkg::UR_SPEED_LS : ur_pkg::UR_SPEED_FS));
		end
		$display("data path done");
	endtask
	task automatic t_oc();
		wr(1'b0, 0, 5'b10100);
		oc_req[0] = 1'b1;
		repeat (5) @(negedge sys_clk);
		// Event pulse stands for one cycle only, look while it is up
		chk({6'h0, ec_port_event[0], cc_port_event[0]}, 8'h01);
		repeat (2) @(negedge sys_clk);
		chk(ec_port_rd[0] & 8'h1c, 8'h0c);
		oc_req[0] = 1'b0;
		repeat (6) @(negedge sys_clk);
		wr(1'b0, 0, 5'b10010);
		chk(ec_port_rd[0] & 8'h1c, 8'h00);
		$display("overcurrent done");
	endtask
	initial begin
		nrst = 1'b0;
		ec_config_flag = 1'b0;
		cc_port_wr = '0;
		ec_port_wr = '0;
		cc_tx = '0;
		ec_tx = '0;
		cc_speed_req = '0;
		attach = 2'b11;
		oc_req = 2'b00;
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk);
		nrst = 1'b1;
		t_reset();
		t_owner();
		t_data();
		t_oc();
		tally_and_finish();
	end
endmodule
`default_nettype wire

/* File: ur_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// Port1 lane watcher; both lanes share one implementation
module ur_chk #(
	parameter int NUM_PORTS = 2
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ec_config_flag,
	input wire ur_pkg::ur_port_wr_t [NUM_PORTS-1:0] ec_port_wr,
	input wire logic [NUM_PORTS-1:0][ur_pkg::PORT_REG_W-1:0] cc_port_rd,
	input wire logic [NUM_PORTS-1:0][ur_pkg::PORT_REG_W-1:0] ec_port_rd,
	input wire logic [NUM_PORTS-1:0] cc_port_event,
	input wire logic [NUM_PORTS-1:0] ec_port_event,
	input wire ur_pkg::ur_line_t [NUM_PORTS-1:0] ec_tx,
	input wire ur_pkg::ur_line_t [NUM_PORTS-1:0] xcvr_tx,
	input wire ur_pkg::ur_speed_t [NUM_PORTS-1:0] xcvr_speed,
	input wire logic [NUM_PORTS-1:0] xcvr_hs_capable,
	input wire logic port1_power_enable_n_out,
	input wire logic port1_power_enable_n_oe_n,
	input wire logic port1_overcurrent_n
);
	logic ec0; // Enhanced side owns port1
	assign ec0 = ec_config_flag && !ec_port_rd[0][ur_pkg::BIT_OWNER];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_cc_view_mask: assert property (cc_port_rd[0] == (ec_port_rd[0] & ur_pkg::CC_VIEW_MASK))
		else $error("companion view shows hidden bits");
	a_cc_low_speed: assert property (!ec0 |=> xcvr_speed[0] != ur_pkg::UR_SPEED_HS)
		else $error("companion port at high speed");
	a_ec_high_speed: assert property (ec0 && xcvr_hs_capable[0] |=> xcvr_speed[0] == ur_pkg::UR_SPEED_HS)
		else $error("enhanced port not at high speed");
	a_tx_route: assert property (ec0 && ec_tx[0].valid |=> xcvr_tx[0] == $past(ec_tx[0]))
		else $error("enhanced beat not routed");
	a_no_power_rise: assert property (ec0 && !ec_port_wr[0].wr |=> !$rose(ec_port_rd[0][ur_pkg::BIT_POWER]))
		else $error("power changed by non-owner");
	a_power_pin: assert property (!port1_power_enable_n_out && port1_power_enable_n_oe_n == !ec_port_rd[0][ur_pkg::BIT_POWER])
		else $error("power pin disagrees");
	a_oc_trip: assert property ($fell(port1_overcurrent_n) |-> ##5 ec_port_rd[0][ur_pkg::BIT_OC_CHANGE] && !ec_port_rd[0][ur_pkg::BIT_POWER])
		else $error("overcurrent not taken");
	a_event_single: assert property ((cc_port_event & ec_port_event) == '0)
		else $error("event to both controllers");
endmodule
bind ur_port_router ur_chk #(.NUM_PORTS(NUM_PORTS)) u_ur_chk (.sys_clk, .nrst, .ec_config_flag,
	.ec_port_wr, .cc_port_rd, .ec_port_rd, .cc_port_event, .ec_port_event, .ec_tx, .xcvr_tx,
	.xcvr_speed, .xcvr_hs_capable, .port1_power_enable_n_out, .port1_power_enable_n_oe_n,
	.port1_overcurrent_n);
`default_nettype wire

/* File: ur_pin_sync.sv */
package ur_pkg;
	// Port register layout, common part seen by both controllers
	localparam int PORT_REG_W = 8;
	localparam int BIT_CONNECT = 0;
	localparam int BIT_ENABLE = 1;
	localparam int BIT_OC_ACTIVE = 2;
	localparam int BIT_OC_CHANGE = 3;
	localparam int BIT_POWER = 4;
	// Enhanced-only part, masked from the companion view
	localparam int BIT_OWNER = 5;
	localparam int BIT_HS_LINE = 6;
	localparam int BIT_PWR_PIN = 7;
	localparam logic [7:0] CC_VIEW_MASK = 8'h1f;
	// Reset values
	localparam logic OWNER_RESET = 1'b1;
	localparam logic POWER_RESET = 1'b0;
	localparam logic ENABLE_RESET = 1'b0;
	localparam logic OC_CHANGE_RESET = 1'b0;
	localparam logic PIN_IDLE = 1'b1;
	// Line signalling rate toward the transceiver
	typedef enum logic [1:0] {UR_SPEED_FS, UR_SPEED_LS, UR_SPEED_HS} ur_speed_t;
	// One port-register write from a controller
	typedef struct packed {
		logic wr;
		logic enable;
		logic power;
		logic clr_oc_change;
		logic owner;
	} ur_port_wr_t;
	// One data beat on a port's line path
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} ur_line_t;
endpackage

`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; a change counts once stages two and three agree
module ur_pin_sync #(
	parameter logic IDLE = 1'b1
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic pin,
	output logic level,
	output logic rose,
	output logic fell
);
	logic s1_ff; // Metastability catcher, read only by s2
	logic s2_ff;
	logic s3_ff;
	logic level_ff; // Accepted level
	logic rose_ff;
	logic fell_ff;

	// Shift chain
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s1_ff <= IDLE;
			s2_ff <= IDLE;
			s3_ff <= IDLE;
		end else begin
			s1_ff <= pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Accept a new level only when the two late stages agree
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			level_ff <= IDLE;
			rose_ff <= 1'b0;
			fell_ff <= 1'b0;
		end else begin
			rose_ff <= (s2_ff == s3_ff) && s3_ff && !level_ff;
			fell_ff <= (s2_ff == s3_ff) && !s3_ff && level_ff;
			if (s2_ff == s3_ff) begin
				level_ff <= s3_ff;
			end
		end
	end

	assign level = level_ff;
	assign rose = rose_ff;
	assign fell = fell_ff;
endmodule
`default_nettype wire

/* File: ur_port_router.sv */
// Summary of operation
// - Companion-owned port runs full or low speed
// - Enhanced-owned port runs high speed when capable
// - Each physical port muxed between both controllers
// - Companion writes ignored while enhanced owns port
// - Enhanced-only port bits hidden from companion
// - Two enhanced bits decide port ownership
// - Reset hands every port to companion
// - Open-drain active-low power enable per port
// - Low overcurrent input means port overcurrent
`timescale 1ns/1ps
`default_nettype none
module ur_port_router #(
	parameter int NUM_PORTS = 2
) (
	input wire logic sys_clk,
	input wire logic nrst,
	// Enhanced controller global routing flag
	input wire logic ec_config_flag,
	// Port-register writes from each controller
	input wire ur_pkg::ur_port_wr_t [NUM_PORTS-1:0] cc_port_wr,
	input wire ur_pkg::ur_port_wr_t [NUM_PORTS-1:0] ec_port_wr,
	// Port-register read views
	output logic [NUM_PORTS-1:0][ur_pkg::PORT_REG_W-1:0] cc_port_rd,
	output logic [NUM_PORTS-1:0][ur_pkg::PORT_REG_W-1:0] ec_port_rd,
	// Port status change pulses
	output logic [NUM_PORTS-1:0] cc_port_event,
	output logic [NUM_PORTS-1:0] ec_port_event,
	// Controller data paths
	input wire ur_pkg::ur_line_t [NUM_PORTS-1:0] cc_tx,
	input wire ur_pkg::ur_line_t [NUM_PORTS-1:0] ec_tx,
	input wire ur_pkg::ur_speed_t [NUM_PORTS-1:0] cc_speed_req,
	output ur_pkg::ur_line_t [NUM_PORTS-1:0] cc_rx,
	output ur_pkg::ur_line_t [NUM_PORTS-1:0] ec_rx,
	// Transceiver side
	output ur_pkg::ur_line_t [NUM_PORTS-1:0] xcvr_tx,
	output ur_pkg::ur_speed_t [NUM_PORTS-1:0] xcvr_speed,
	input wire ur_pkg::ur_line_t [NUM_PORTS-1:0] xcvr_rx,
	input wire logic [NUM_PORTS-1:0] xcvr_connect,
	input wire logic [NUM_PORTS-1:0] xcvr_hs_capable,
	// Power enable pins, open-drain
	input wire logic port1_power_enable_n_in,
	output logic port1_power_enable_n_out,
	output logic port1_power_enable_n_oe_n,
	input wire logic port2_power_enable_n_in,
	output logic port2_power_enable_n_out,
	output logic port2_power_enable_n_oe_n,
	// Overcurrent sense pins
	input wire logic port1_overcurrent_n,
	input wire logic port2_overcurrent_n
);
	// Pins are named per port, so the count is fixed by the package pins
	if (NUM_PORTS != 2) begin : g_bad_ports
		$error("ur_port_router supports exactly two ports");
	end

	logic [NUM_PORTS-1:0] oc_pin_n; // Raw overcurrent pins
	logic [NUM_PORTS-1:0] pwr_pin_n; // Raw power pin readback
	logic [NUM_PORTS-1:0] oc_level_n; // Synchronised overcurrent level
	logic [NUM_PORTS-1:0] oc_rose;
	logic [NUM_PORTS-1:0] oc_fell;
	logic [NUM_PORTS-1:0] pwr_level_n; // Synchronised power pin level
	logic [NUM_PORTS-1:0] ec_owns; // Enhanced controller owns port
	logic [NUM_PORTS-1:0] owner_ff; // Port owner bit, high is companion
	logic [NUM_PORTS-1:0] ec_owns_ff; // Ownership last cycle
	logic [NUM_PORTS-1:0] enable_ff;
	logic [NUM_PORTS-1:0] power_ff;
	logic [NUM_PORTS-1:0] oc_change_ff;
	logic [NUM_PORTS-1:0] connect_ff; // Connect last cycle
	logic [NUM_PORTS-1:0] cc_event_ff;
	logic [NUM_PORTS-1:0] ec_event_ff;
	ur_pkg::ur_port_wr_t [NUM_PORTS-1:0] own_wr; // Write from the owner
	logic [NUM_PORTS-1:0][ur_pkg::PORT_REG_W-1:0] port_reg;
	ur_pkg::ur_line_t [NUM_PORTS-1:0] xcvr_tx_ff;
	ur_pkg::ur_speed_t [NUM_PORTS-1:0] xcvr_speed_ff;
	ur_pkg::ur_line_t [NUM_PORTS-1:0] cc_rx_ff;
	ur_pkg::ur_line_t [NUM_PORTS-1:0] ec_rx_ff;

	assign oc_pin_n = {port2_overcurrent_n, port1_overcurrent_n};
	assign pwr_pin_n = {port2_power_enable_n_in, port1_power_enable_n_in};

	genvar gp;
	for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
		// Overcurrent sense, low is active
		ur_pin_sync #(
			.IDLE(ur_pkg::PIN_IDLE)
		) u_oc_sync (
			.sys_clk(sys_clk),
			.nrst(nrst),
			.pin(oc_pin_n[gp]),
			.level(oc_level_n[gp]),
			.rose(oc_rose[gp]),
			.fell(oc_fell[gp])
		);

		// Readback of the power pin, shows a board-side short or pull
		ur_pin_sync #(
			.IDLE(ur_pkg::PIN_IDLE)
		) u_pwr_sync (
			.sys_clk(sys_clk),
			.nrst(nrst),
			.pin(pwr_pin_n[gp]),
			.level(pwr_level_n[gp]),
			.rose(),
			.fell()
		);

		// Enhanced owns only when routing is on and owner bit released
		assign ec_owns[gp] = ec_config_flag && !owner_ff[gp];

		// Only the owner's write reaches the port state
		always_comb begin
			if (ec_owns[gp]) begin
				own_wr[gp] = ec_port_wr[gp];
			end else begin
				own_wr[gp] = cc_port_wr[gp];
			end
			own_wr[gp].owner = 1'b0; // Owner bit travels separately
			if (ec_owns[gp]) begin
				own_wr[gp].wr = ec_port_wr[gp].wr;
			end
		end

		// Owner bit, written by the enhanced driver at any time
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				owner_ff[gp] <= ur_pkg::OWNER_RESET;
			end else if (ec_port_wr[gp].wr) begin
				owner_ff[gp] <= ec_port_wr[gp].owner;
			end
		end

		// Ownership and connect history for change detection
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				ec_owns_ff[gp] <= 1'b0;
				connect_ff[gp] <= 1'b0;
			end else begin
				ec_owns_ff[gp] <= ec_owns[gp];
				connect_ff[gp] <= xcvr_connect[gp];
			end
		end

		// Port enable; a hand-over drops it so the new owner starts clean
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				enable_ff[gp] <= ur_pkg::ENABLE_RESET;
			end else if (ec_owns[gp] != ec_owns_ff[gp] || !xcvr_connect[gp]) begin
				enable_ff[gp] <= 1'b0;
			end else if (own_wr[gp].wr) begin
				enable_ff[gp] <= own_wr[gp].enable && power_ff[gp];
			end
		end

		// Port power; overcurrent wins over any write
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				power_ff[gp] <= ur_pkg::POWER_RESET;
			end else if (!oc_level_n[gp]) begin
				power_ff[gp] <= 1'b0;
			end else if (own_wr[gp].wr) begin
				power_ff[gp] <= own_wr[gp].power;
			end
		end

		// Overcurrent change flag; a new edge beats a clear
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				oc_change_ff[gp] <= ur_pkg::OC_CHANGE_RESET;
			end else if (oc_rose[gp] || oc_fell[gp]) begin
				oc_change_ff[gp] <= 1'b1;
			end else if (own_wr[gp].wr && own_wr[gp].clr_oc_change) begin
				oc_change_ff[gp] <= 1'b0;
			end
		end

		// Status events go only to whoever owns the port now
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				cc_event_ff[gp] <= 1'b0;
				ec_event_ff[gp] <= 1'b0;
			end else begin
				cc_event_ff[gp] <= !ec_owns[gp] && (oc_rose[gp] || oc_fell[gp]
					|| xcvr_connect[gp] != connect_ff[gp]
					|| ec_owns[gp] != ec_owns_ff[gp]);
				ec_event_ff[gp] <= ec_owns[gp] && (oc_rose[gp] || oc_fell[gp]
					|| xcvr_connect[gp] != connect_ff[gp]
					|| ec_owns[gp] != ec_owns_ff[gp]);
			end
		end

		// Full port register image
		always_comb begin
			port_reg[gp] = '0;
			port_reg[gp][ur_pkg::BIT_CONNECT] = xcvr_connect[gp];
			port_reg[gp][ur_pkg::BIT_ENABLE] = enable_ff[gp];
			port_reg[gp][ur_pkg::BIT_OC_ACTIVE] = !oc_level_n[gp];
			port_reg[gp][ur_pkg::BIT_OC_CHANGE] = oc_change_ff[gp];
			port_reg[gp][ur_pkg::BIT_POWER] = power_ff[gp];
			port_reg[gp][ur_pkg::BIT_OWNER] = owner_ff[gp];
			port_reg[gp][ur_pkg::BIT_HS_LINE] = xcvr_speed_ff[gp] == ur_pkg::UR_SPEED_HS;
			port_reg[gp][ur_pkg::BIT_PWR_PIN] = !pwr_level_n[gp];
		end

		// Companion sees the common bits only
		assign cc_port_rd[gp] = port_reg[gp] & ur_pkg::CC_VIEW_MASK;
		assign ec_port_rd[gp] = port_reg[gp];

		// Transmit mux and line rate, registered to keep glitches off the line
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				xcvr_tx_ff[gp] <= '0;
				xcvr_speed_ff[gp] <= ur_pkg::UR_SPEED_FS;
			end else if (ec_owns[gp]) begin
				xcvr_tx_ff[gp] <= ec_tx[gp];
				if (xcvr_hs_capable[gp]) begin
					xcvr_speed_ff[gp] <= ur_pkg::UR_SPEED_HS;
				end else begin
					xcvr_speed_ff[gp] <= ur_pkg::UR_SPEED_FS;
				end
			end else begin
				xcvr_tx_ff[gp] <= cc_tx[gp];
				if (cc_speed_req[gp] == ur_pkg::UR_SPEED_LS) begin
					xcvr_speed_ff[gp] <= ur_pkg::UR_SPEED_LS;
				end else begin
					xcvr_speed_ff[gp] <= ur_pkg::UR_SPEED_FS;
				end
			end
		end

		// Receive path reaches the owner; the other side sees idle
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				cc_rx_ff[gp] <= '0;
				ec_rx_ff[gp] <= '0;
			end else begin
				cc_rx_ff[gp] <= ec_owns[gp] ? '0 : xcvr_rx[gp];
				ec_rx_ff[gp] <= ec_owns[gp] ? xcvr_rx[gp] : '0;
			end
		end
	end

	assign cc_port_event = cc_event_ff;
	assign ec_port_event = ec_event_ff;
	assign xcvr_tx = xcvr_tx_ff;
	assign xcvr_speed = xcvr_speed_ff;
	assign cc_rx = cc_rx_ff;
	assign ec_rx = ec_rx_ff;

	// Open-drain: pull low to power the port, release otherwise
	assign port1_power_enable_n_out = 1'b0;
	assign port1_power_enable_n_oe_n = !power_ff[0];
	assign port2_power_enable_n_out = 1'b0;
	assign port2_power_enable_n_oe_n = !power_ff[1];
endmodule
`default_nettype wire

/* File: ur_xcvr_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Transceiver plus attached device, two lanes
module ur_xcvr_model (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire ur_pkg::ur_line_t [1:0] xcvr_tx,
	input wire logic [1:0] attach,
	input wire logic [1:0] oc_req,
	output ur_pkg::ur_line_t [1:0] xcvr_rx,
	output logic [1:0] xcvr_connect,
	output logic [1:0] xcvr_hs_capable,
	output logic [1:0] oc_n
);
	// Device answers each beat inverted; idle data keeps toggling
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			xcvr_rx <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				xcvr_rx[i].valid <= xcvr_tx[i].valid;
				xcvr_rx[i].data <= xcvr_tx[i].valid ? ~xcvr_tx[i].data : ~xcvr_rx[i].data;
			end
		end
	end
	assign xcvr_connect = attach;
	assign xcvr_hs_capable = attach; // Attached device is high-speed capable
	assign oc_n = ~oc_req; // Idle high unless a fault is ordered
endmodule
`default_nettype wire
